// ==== reset_startup_clock_config_tb.sv ====
// self-checking bench for the reset and startup clock block
`timescale 1ns/1ps
module reset_startup_clock_config_tb;
  import rst_cfg_pkg::*;
  logic clk = 0, rst = 1, hw = 0, sw = 0, wdt = 0, busy = 0, lock = 0;
  logic [15:0] pd = 16'h0000;
  logic [15:0] pins;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  logic cpu_rst, cancel, abort, pu, fetch, byp, presc, amp, bus8, ube, lfo;
  logic [23:0] faddr;
  logic [5:0] fx2;
  logic [31:0] rd;
  logic er, seen;
  int error_cnt = 0, checked = 0;
  int code, bw, ec, eb, s, n;
  int fx2_tab [8] = '{32, 1, 20, 2, 10, 16, 6, 8};
  int cause_tab [3] = '{4, 8, 2};

  rst_cfg_ctrl u_dut (.CLK_IN(clk), .RESET_IN(rst), .HW_RESET_IN(hw),
    .SOFTWARE_RESET_INSTR_IN(sw), .WDT_OVERFLOW_IN(wdt),
    .RAM_WRITE_BUSY_IN(busy), .PLL_LOCK_IN(lock), .PORT0_IN(pins),
    .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .CPU_RESET_OUT(cpu_rst),
    .HOLD_CANCEL_OUT(cancel), .EXT_BUS_ABORT_OUT(abort),
    .PORT0_PULLUP_EN_OUT(pu), .FETCH_START_OUT(fetch),
    .FETCH_ADDR_OUT(faddr), .CLK_FACTOR_X2_OUT(fx2),
    .PLL_BYPASS_OUT(byp), .PRESCALER_OUT(presc), .OSC_AMP_REQ_OUT(amp),
    .BUS_8BIT_OUT(bus8), .UPPER_BYTE_ENABLE_OUT(ube),
    .LOW_FREQ_OSC_DISABLE_OUT(lfo));
  strap_board u_board (.clk_in(clk), .pullup_en_in(pu), .pulldown_in(pd),
    .pins_out(pins));

  initial begin
    forever #4 clk = ~clk;
  end

  task results;
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task fail(input string m);
    error_cnt++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask

  task chk(input logic [31:0] v, input logic [31:0] e, input string m);
    checked++;
    if (v !== e) begin
      fail(m);
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fail("run too long");
    results();
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin
      fail("no ready");
      results();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask

  task wait_fetch(input int lim, input bit must);
    seen = 0;
    for (int k = 0; k < lim && !seen; k++) begin
      @(posedge clk);
      seen = (fetch === 1'b1);
    end
    if (must && !seen) begin
      fail("no fetch start");
      results();
    end
  endtask

  // read startup status against the model, then clear the causes
  task status(input logic [3:0] c);
    apb(1'b0, STARTUP_STATUS_REG_OFS, 32'h0000_0000);
    chk(rd, {20'h0_0000, c, 3'h0, 1'b1, 1'(!eb), 3'(ec)}, "status");
    chk(bus8, !eb, "bus width");
    apb(1'b1, STARTUP_STATUS_REG_OFS, 32'h0000_0f00);
  endtask

  initial begin
    void'($urandom(32'h86b5_f54b));
    for (code = 0; code < 8; code++) begin
      bw = $urandom_range(1);
      ec = code;
      eb = bw;
      pd <= 16'((7 - code) << 13 | (1 - bw) << 7)
        | 16'($urandom & 32'h0000_1f7f);
      lock <= 1'b0;
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_fetch(2800, 0);
      chk(seen, code == 3 || code == 1, "fetch before lock");
      lock <= 1'b1;
      if (!seen) begin
        wait_fetch(40, 1);
      end
      chk(cpu_rst, 0, "cpu reset");
      chk(faddr, 0, "fetch address");
      chk(fx2, fx2_tab[code], "factor");
      chk(byp, code == 3 || code == 1, "bypass");
      chk(presc, code == 1, "prescaler");
      chk(amp, code == 1, "osc amplifier");
      chk(pu, 0, "pull-up after reset");
      status(4'h1);
    end
    apb(1'b0, SYSTEM_CONFIG_REG_OFS, 32'h0000_0000);
    chk(rd, 0, "config reset value");
    apb(1'b0, RTC_CONTROL_REG_OFS, 32'h0000_0000);
    chk(rd, 0, "rtc reset value");
    chk(ube, eb, "upper byte enable");
    apb(1'b1, SYSTEM_CONFIG_REG_OFS, 32'hffff_ffff);
    apb(1'b0, SYSTEM_CONFIG_REG_OFS, 32'h0000_0000);
    chk(rd, 1, "config bit");
    chk(ube, 0, "byte enable off");
    // low frequency oscillator unused, so it is switched off
    apb(1'b1, RTC_CONTROL_REG_OFS, 32'h0000_0001);
    chk(lfo, 1, "osc disable");
    apb(1'b1, 12'h0ff, 32'hffff_ffff);
    chk(er, 1, "unmapped write");
    apb(1'b0, 12'h0ff, 32'h0000_0000);
    chk(rd, 0, "unmapped read");
    pd <= 16'hffff;
    for (s = 0; s < 3; s++) begin
      busy <= (s == 0);
      hw <= (s == 2);
      sw <= (s == 0);
      wdt <= (s == 1);
      @(posedge clk);
      sw <= 1'b0;
      wdt <= 1'b0;
      repeat (20) @(posedge clk);
      chk(cpu_rst, 1, "reset taken");
      chk(cancel, 1, "hold cancel");
      chk(abort, 1, "bus abort");
      chk(pu, s != 0, "pull-up while ram busy");
      busy <= 1'b0;
      hw <= 1'b0;
      wait_fetch(2800, 1);
      if (s == 2) begin
        eb = 0;
      end
      status(4'(cause_tab[s]));
    end
    // a software reset while the clock settles restarts the hold phase
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    repeat (300) @(posedge clk);
    chk(pu, 0, "pull-up while settling");
    chk(cpu_rst, 1, "cpu held while settling");
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    repeat (20) @(posedge clk);
    chk(pu, 1, "hold restarted in settle");
    chk(cancel, 1, "hold cancel in settle");
    wait_fetch(2800, 1);
    status(4'h4);
    results();
  end
endmodule

// ==== rst_cfg_ctrl.sv ====
// reset recognition, port 0 strap sampling and cpu clock selection
//
// Notes on behaviour
// - a reset starts on the hardware reset pin, a software reset or a watchdog overflow.
// - an internal ram write already running finishes before the reset procedure starts.
// - every pending internal hold state is cancelled once a reset is recognised.
// - an external memory cycle in progress is aborted, not completed, on reset.
// - when the reset procedure ends, fetching starts at 0000h of code segment 0.
// - port 0 weak pull-ups are on only in the reset hold phase, so open straps read one.
// - all straps are sampled at power-on reset; other resets keep some earlier values.
// - all clock straps high, the default, runs the cpu at four times the input clock.
// - code 011 is direct drive, the cpu clock equals the input and the pll is bypassed.
// - code 001 halves the input through a prescaler and needs the oscillator amplifier.
// - a low bus width strap picks an 8-bit bus and keeps the upper byte enable off.
`timescale 1ns/1ps
module rst_cfg_ctrl
  import rst_cfg_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic HW_RESET_IN,
  input wire logic SOFTWARE_RESET_INSTR_IN,
  input wire logic WDT_OVERFLOW_IN,
  input wire logic RAM_WRITE_BUSY_IN,
  input wire logic PLL_LOCK_IN,
  input wire logic [PORT0_W-1:0] PORT0_IN,
  input wire apb_req_type APB_REQ_IN,
  output apb_rsp_type APB_RSP_OUT,
  output logic CPU_RESET_OUT,
  output logic HOLD_CANCEL_OUT,
  output logic EXT_BUS_ABORT_OUT,
  output logic PORT0_PULLUP_EN_OUT,
  output logic FETCH_START_OUT,
  output logic [23:0] FETCH_ADDR_OUT,
  output logic [5:0] CLK_FACTOR_X2_OUT,
  output logic PLL_BYPASS_OUT,
  output logic PRESCALER_OUT,
  output logic OSC_AMP_REQ_OUT,
  output logic BUS_8BIT_OUT,
  output logic UPPER_BYTE_ENABLE_OUT,
  output logic LOW_FREQ_OSC_DISABLE_OUT
);

  typedef struct packed {
    seq_type seq;
    logic [11:0] cnt;
    logic por;
    logic [2:0] hw_s;
    logic hw_level;
    logic [2:0] lock_s;
    logic lock_level;
    logic [PORT0_W-1:0] p0_s1;
    logic [PORT0_W-1:0] p0_s2;
    logic [PORT0_W-1:0] p0_s3;
    logic [PORT0_W-1:0] p0_level;
    logic [2:0] clk_code;
    logic [5:0] factor;
    logic bus8;
    logic byte_off;
    logic osc_off;
    logic [3:0] cause;
    logic [31:0] rdata;
    logic err;
    logic fetch;
  } block_state_type;

  block_state_type st;
  block_state_type next_st;
  logic trigger;
  logic recognise;
  logic bypass;
  logic [3:0] cause_set;
  logic [3:0] cause_clr;
  logic [2:0] strap_clk;
  logic apb_setup;
  logic apb_write;

  function automatic logic [5:0] factor_x2(input logic [2:0] code);
    case (code)
      3'h7: factor_x2 = FX2_CODE7;
      3'h6: factor_x2 = FX2_CODE6;
      3'h5: factor_x2 = FX2_CODE5;
      3'h4: factor_x2 = FX2_CODE4;
      3'h3: factor_x2 = FX2_CODE3;
      3'h2: factor_x2 = FX2_CODE2;
      3'h1: factor_x2 = FX2_CODE1;
      default: factor_x2 = FX2_CODE0;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    addr_hit = (addr == SYSTEM_CONFIG_REG_OFS) ||
      (addr == RTC_CONTROL_REG_OFS) || (addr == STARTUP_STATUS_REG_OFS);
  endfunction

  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] addr, input block_state_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == SYSTEM_CONFIG_REG_OFS) begin
      w[UPPER_BYTE_ENABLE_OFF_BIT] = s.byte_off;
    end
    if (addr == RTC_CONTROL_REG_OFS) begin
      w[LOW_FREQ_OSC_DISABLE_BIT] = s.osc_off;
    end
    if (addr == STARTUP_STATUS_REG_OFS) begin
      w[STS_CLK_CODE_LSB +: 3] = s.clk_code;
      w[STS_BUS_8BIT_BIT] = s.bus8;
      w[STS_CLK_READY_BIT] = (s.seq == ST_RUN);
      w[STS_CAUSE_LSB +: 4] = s.cause;
    end
    read_word = w;
  endfunction

  assign strap_clk = st.p0_level[CLK_STRAP_LSB +: 3];
  assign trigger = st.hw_level | SOFTWARE_RESET_INSTR_IN | WDT_OVERFLOW_IN;
  assign recognise = trigger && (st.seq == ST_RUN || st.seq == ST_SETTLE);
  assign cause_set = recognise ?
    {WDT_OVERFLOW_IN, SOFTWARE_RESET_INSTR_IN, st.hw_level, 1'b0} : 4'h0;
  assign bypass = (st.clk_code == CLK_CODE_DIRECT) ||
    (st.clk_code == CLK_CODE_PRESCALE);
  assign apb_setup = APB_REQ_IN.psel && !APB_REQ_IN.penable;
  assign apb_write = APB_REQ_IN.psel && APB_REQ_IN.penable &&
    APB_REQ_IN.pwrite && !st.err;

  always_comb begin
    next_st = st;
    next_st.fetch = 1'b0;
    cause_clr = 4'h0;
    // pin synchronisers: a change counts once stages two and three agree
    next_st.hw_s = {st.hw_s[1:0], HW_RESET_IN};
    if (st.hw_s[1] == st.hw_s[2]) begin
      next_st.hw_level = st.hw_s[2];
    end
    next_st.lock_s = {st.lock_s[1:0], PLL_LOCK_IN};
    if (st.lock_s[1] == st.lock_s[2]) begin
      next_st.lock_level = st.lock_s[2];
    end
    next_st.p0_s1 = PORT0_IN;
    next_st.p0_s2 = st.p0_s1;
    next_st.p0_s3 = st.p0_s2;
    next_st.p0_level = (st.p0_s2 & st.p0_s3) |
      (st.p0_level & (st.p0_s2 ^ st.p0_s3));
    // reset sequence
    case (st.seq)
      ST_RUN: begin
        if (trigger) begin
          next_st.cnt = RESET_HOLD_CYC;
          if (RAM_WRITE_BUSY_IN) begin
            next_st.seq = ST_WAIT_RAM;
          end else begin
            next_st.seq = ST_HOLD;
          end
        end
      end
      ST_WAIT_RAM: begin
        if (!RAM_WRITE_BUSY_IN) begin
          next_st.seq = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (st.cnt != 12'h000) begin
          next_st.cnt = st.cnt - 12'h001;
        end else if (!st.hw_level) begin
          // latch straps at release; hw reset resamples bus width only
          if (st.por) begin
            next_st.clk_code = strap_clk;
            next_st.factor = factor_x2(strap_clk);
          end
          if (st.por || st.cause[1]) begin
            next_st.bus8 = !st.p0_level[BUS_WIDTH_STRAP_BIT];
          end
          next_st.por = 1'b0;
          next_st.cnt = SETTLE_CYC;
          next_st.seq = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (trigger) begin
          next_st.cnt = RESET_HOLD_CYC;
          next_st.seq = ST_HOLD;
        end else if (st.cnt != 12'h000) begin
          next_st.cnt = st.cnt - 12'h001;
        end else if (bypass || st.lock_level) begin
          next_st.seq = ST_START;
        end
      end
      ST_START: begin
        next_st.fetch = 1'b1;
        next_st.seq = ST_RUN;
      end
      default: begin
        next_st.seq = ST_HOLD;
      end
    endcase
    // register bus: read data is taken in the setup cycle
    if (apb_setup) begin
      next_st.rdata = read_word(APB_REQ_IN.paddr, st);
      next_st.err = !addr_hit(APB_REQ_IN.paddr);
    end
    if (apb_write) begin
      case (APB_REQ_IN.paddr)
        SYSTEM_CONFIG_REG_OFS: begin
          next_st.byte_off = APB_REQ_IN.pwdata[UPPER_BYTE_ENABLE_OFF_BIT];
        end
        RTC_CONTROL_REG_OFS: begin
          next_st.osc_off = APB_REQ_IN.pwdata[LOW_FREQ_OSC_DISABLE_BIT];
        end
        STARTUP_STATUS_REG_OFS: begin
          cause_clr = APB_REQ_IN.pwdata[STS_CAUSE_LSB +: 4];
        end
        default: begin
          cause_clr = 4'h0;
        end
      endcase
    end
    // a cause arriving with its clear stays set
    next_st.cause = (st.cause & ~cause_clr) | cause_set;
    if (RESET_IN) begin
      next_st = '0;
      next_st.seq = ST_HOLD;
      next_st.cnt = RESET_HOLD_CYC;
      next_st.por = 1'b1;
      next_st.clk_code = CLK_CODE_DEFAULT;
      next_st.factor = FX2_CODE7;
      next_st.cause = CAUSE_POWER_ON;
      next_st.rdata = REG_RESET;
    end
  end

  always_ff @(posedge CLK_IN) begin
    st <= next_st;
  end

  assign CPU_RESET_OUT = (st.seq != ST_RUN);
  assign HOLD_CANCEL_OUT = (st.seq == ST_WAIT_RAM) ||
    (st.seq == ST_HOLD);
  assign EXT_BUS_ABORT_OUT = (st.seq == ST_WAIT_RAM) ||
    (st.seq == ST_HOLD);
  assign PORT0_PULLUP_EN_OUT = (st.seq == ST_HOLD);
  assign FETCH_START_OUT = st.fetch;
  assign FETCH_ADDR_OUT = FETCH_ADDR;
  assign CLK_FACTOR_X2_OUT = st.factor;
  assign PLL_BYPASS_OUT = bypass;
  assign PRESCALER_OUT = (st.clk_code == CLK_CODE_PRESCALE);
  assign OSC_AMP_REQ_OUT = (st.clk_code == CLK_CODE_PRESCALE);
  assign BUS_8BIT_OUT = st.bus8;
  assign UPPER_BYTE_ENABLE_OUT = !st.bus8 && !st.byte_off;
  assign LOW_FREQ_OSC_DISABLE_OUT = st.osc_off;
  assign APB_RSP_OUT.prdata = st.rdata;
  assign APB_RSP_OUT.pready = 1'b1;
  assign APB_RSP_OUT.pslverr = APB_REQ_IN.psel && APB_REQ_IN.penable &&
    st.err;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_recognise;
    (st.seq == ST_RUN) && trigger;
  endsequence

  sequence s_release;
    (st.seq == ST_HOLD) && (st.cnt == 12'h000) && !st.hw_level;
  endsequence

  a_reset_sources: assert property (
    s_recognise |=> CPU_RESET_OUT)
    else $error("reset source not taken");
  a_ram_write_first: assert property (
    (st.seq == ST_WAIT_RAM && RAM_WRITE_BUSY_IN) |=>
      (st.seq == ST_WAIT_RAM) && !PORT0_PULLUP_EN_OUT)
    else $error("reset began during ram write");
  a_hold_cancel: assert property (
    s_recognise |=> HOLD_CANCEL_OUT)
    else $error("hold states not cancelled");
  a_ext_abort: assert property (
    s_recognise ##1 (st.seq == ST_WAIT_RAM) |-> EXT_BUS_ABORT_OUT)
    else $error("external cycle not aborted");
  a_fetch_origin: assert property (
    FETCH_START_OUT |-> !CPU_RESET_OUT && $past(CPU_RESET_OUT) &&
      (FETCH_ADDR_OUT == FETCH_ADDR))
    else $error("fetch start wrong");
  a_pullup_in_reset: assert property (
    PORT0_PULLUP_EN_OUT |-> CPU_RESET_OUT)
    else $error("pull-ups on outside reset");
  a_por_sampling: assert property (
    (s_release and (st.por == 1'b1)) |=> (st.clk_code == $past(strap_clk)))
    else $error("straps not sampled at power-on");
  a_factor_map: assert property (
    CLK_FACTOR_X2_OUT == factor_x2(st.clk_code))
    else $error("clock factor mismatch");
  a_default_x4: assert property (
    (st.clk_code == CLK_CODE_DEFAULT) |-> (CLK_FACTOR_X2_OUT == FX2_CODE7))
    else $error("default factor not four");
  a_direct_drive: assert property (
    (st.clk_code == CLK_CODE_DIRECT) |->
      PLL_BYPASS_OUT && (CLK_FACTOR_X2_OUT == FX2_CODE3))
    else $error("direct drive wrong");
  a_prescale_mode: assert property (
    (st.clk_code == CLK_CODE_PRESCALE) |-> PRESCALER_OUT &&
      OSC_AMP_REQ_OUT && (CLK_FACTOR_X2_OUT == FX2_CODE1))
    else $error("prescaler mode wrong");
  a_bus_width: assert property (
    BUS_8BIT_OUT |-> !UPPER_BYTE_ENABLE_OUT)
    else $error("upper byte enable on with 8-bit bus");
  a_strap_hold: assert property (
    (st.seq == ST_RUN) [*2] |-> $stable(st.clk_code) && $stable(st.bus8))
    else $error("straps changed while running");
  a_settle_hold: assert property (
    (st.seq == ST_SETTLE && st.cnt != 12'h000) |=> CPU_RESET_OUT)
    else $error("cpu released before clock settled");

endmodule

// ==== rst_cfg_pkg.sv ====
// constants, types and register map of the reset and startup clock block
package rst_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int PORT0_W = 16;

  localparam logic [ADDR_W-1:0] SYSTEM_CONFIG_REG_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] RTC_CONTROL_REG_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] STARTUP_STATUS_REG_OFS = 12'h008;

  localparam int UPPER_BYTE_ENABLE_OFF_BIT = 0;
  localparam int LOW_FREQ_OSC_DISABLE_BIT = 0;
  localparam int STS_CLK_CODE_LSB = 0;
  localparam int STS_BUS_8BIT_BIT = 3;
  localparam int STS_CLK_READY_BIT = 4;
  localparam int STS_CAUSE_LSB = 8;

  localparam logic [3:0] CAUSE_POWER_ON = 4'h1;
  localparam int CLK_STRAP_LSB = 13;
  localparam int BUS_WIDTH_STRAP_BIT = 7;

  localparam logic [2:0] CLK_CODE_DEFAULT = 3'h7;
  localparam logic [2:0] CLK_CODE_DIRECT = 3'h3;
  localparam logic [2:0] CLK_CODE_PRESCALE = 3'h1;

  // cpu clock factor held as twice the factor, so one half fits
  localparam logic [5:0] FX2_CODE7 = 6'h08;
  localparam logic [5:0] FX2_CODE6 = 6'h06;
  localparam logic [5:0] FX2_CODE5 = 6'h10;
  localparam logic [5:0] FX2_CODE4 = 6'h0A;
  localparam logic [5:0] FX2_CODE3 = 6'h02;
  localparam logic [5:0] FX2_CODE2 = 6'h14;
  localparam logic [5:0] FX2_CODE1 = 6'h01;
  localparam logic [5:0] FX2_CODE0 = 6'h20;

  localparam logic [23:0] FETCH_ADDR = 24'h00_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int RESET_HOLD_NS = 1000;
  localparam int SETTLE_US = 20;
  localparam logic [11:0] RESET_HOLD_CYC =
    12'((RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] SETTLE_CYC =
    12'((SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT_RAM, ST_HOLD, ST_SETTLE, ST_START
  } seq_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
endpackage

// ==== strap_board.sv ====
// board strap resistors and port 0 pins as seen by the block
`timescale 1ns/1ps
module strap_board (
  input wire logic clk_in,
  input wire logic pullup_en_in,
  input wire logic [15:0] pulldown_in,
  output logic [15:0] pins_out
);
  logic [15:0] drift = 16'h5a5a;
  // a floating pin wanders once the weak pull-ups let go
  always_ff @(posedge clk_in) begin
    drift <= ~drift;
  end
  // board pull-downs win, open straps read one in the reset hold phase
  // a crystal is fitted, so no clock is forced onto the pins
  assign pins_out = ~pulldown_in & (pullup_en_in ? 16'hffff : drift);
endmodule
